/* core/udif_ep_summary.sv */
/*
 * Endpoint interrupt summary: bit n follows whether endpoint n has any
 * pending flag. Read-only to software.
 * Assumes per-endpoint pending vectors are synchronous to clk_in.
 */
`timescale 1ns/10ps
`default_nettype none
module udif_ep_summary
    import udif_pkg::*;
#(
    parameter int NUM_EP = 16,
    parameter int EP_FLAG_W = 8
)(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [NUM_EP*EP_FLAG_W-1:0] ep_flags_in,
    output logic [NUM_EP-1:0] summary_out
);
    import udif_pkg::*;
    genvar n;
    generate
        for (n = 0; n < NUM_EP; n++)
        begin : g_ep
            // set on any flag, cleared by hardware when none left
            always_ff @(posedge clk_in)
            begin
                if (sys_rst_in)
                    summary_out[n] <= EP_SUMMARY_RST[n];
                else
                    summary_out[n] <= |ep_flags_in[n*EP_FLAG_W +: EP_FLAG_W];
            end
        end
    endgenerate
endmodule : udif_ep_summary
`default_nettype wire

/* core/udif_idle_timer.sv */
/*
 * Suspend detector: counts consecutive clock cycles of bus idle in J
 * state and pulses once when the limit is reached.
 * Assumes line state is synchronous to clk_in.
 */
`timescale 1ns/10ps
`default_nettype none
module udif_idle_timer
    import udif_pkg::*;
#(
    parameter int LIMIT = udif_pkg::SUSPEND_CYC
)(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic bus_idle_j_in,
    output logic suspend_pulse_out
);
    import udif_pkg::*;
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LIM = CW'(LIMIT - 1);
    logic [CW-1:0] idle_cnt;
    udif_sus_t state;
    // idle counter and state; one pulse per idle stretch
    always_ff @(posedge clk_in)
    begin
        suspend_pulse_out <= 1'b0;
        if (sys_rst_in || !bus_idle_j_in)
        begin
            idle_cnt <= '0;
            state <= UDIF_SUS_ACTIVE;
        end
        else
        begin
            case (state)
                UDIF_SUS_ACTIVE:
                begin
                    idle_cnt <= '0;
                    state <= UDIF_SUS_IDLE;
                end
                UDIF_SUS_IDLE:
                begin
                    if (idle_cnt == LIM - 1'b1)
                    begin
                        suspend_pulse_out <= 1'b1;
                        state <= UDIF_SUS_DONE;
                    end
                    idle_cnt <= idle_cnt + 1'b1;
                end
                default:
                begin
                    state <= UDIF_SUS_DONE;
                end
            endcase
        end
    end
endmodule : udif_idle_timer
`default_nettype wire

/* core/udif_pkg.sv */
/*
 * Constants for the USB device interrupt flag block: register offsets,
 * flag bit positions, reset values and timing counts.
 * Assumes a 10 MHz single clock and a plain strobe register port.
 */
package udif_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register offsets
    localparam logic [7:0] OFF_BUS_FLAGS = 8'h1c;
    localparam logic [7:0] OFF_IRQ_EN_CLR = 8'h14;
    localparam logic [7:0] OFF_IRQ_EN_SET = 8'h18;
    localparam logic [7:0] OFF_EP_SUMMARY = 8'h20;
    localparam logic [7:0] OFF_FRAME = 8'h24;
    // bus-event flag bit positions
    localparam int BIT_SUSPEND = 0;
    localparam int BIT_SOF = 2;
    localparam int BIT_END_OF_BUS_RESET_FLAG = 3;
    localparam int FLAG_W = 4;
    localparam logic [3:0] FLAG_MASK = 4'hd;
    // reset values
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [15:0] EP_SUMMARY_RST = 16'h0000;
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int FRAME_US = 1000;
    localparam int SUSPEND_MS = 3;
    localparam int FRAME_CYC = CLK_HZ / 1_000_000 * FRAME_US;
    localparam int SUSPEND_CYC = FRAME_CYC * SUSPEND_MS;
    localparam int FRAME_NUMBER_W = 11;
    localparam int MICROFRAME_NUMBER_W = 3;
    typedef enum logic [1:0] {
        UDIF_SUS_ACTIVE = 2'b00,
        UDIF_SUS_IDLE = 2'b01,
        UDIF_SUS_DONE = 2'b11
    } udif_sus_t;
endpackage : udif_pkg

/* core/udif_top.sv */
/*
 * USB device interrupt flag block: sticky bus-event flags (suspend,
 * start of frame, end of bus reset) with write-one-to-clear, enables,
 * frame number capture and the endpoint summary vector.
 * Assumes event inputs are single-cycle pulses synchronous to clk_in and
 * a register master following the plain strobe protocol.
 */
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - end-of-reset sets bit 3, interrupts when enabled
// - writing one clears a bus-event flag
// - writing zero leaves flags unchanged
// - start-of-frame sets bit 2, interrupts when enabled
// - frame start stores frame number, clears microframe in high speed only
// - 3 ms J idle sets suspend bit 0
// - sixteen summary bits follow endpoint flags
// - summary bit clears when endpoint idle
// - summary read-only, resets to zero
module udif_top
    import udif_pkg::*;
#(
    parameter int SUSPEND_CYCLES = udif_pkg::SUSPEND_CYC,
    parameter int NUM_EP = 16,
    parameter int EP_FLAG_W = 8
)(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [udif_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [udif_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [udif_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic bus_reset_end_in,
    input wire logic sof_token_in,
    input wire logic [udif_pkg::FRAME_NUMBER_W-1:0] sof_frame_in,
    input wire logic high_speed_in,
    input wire logic microframe_tick_in,
    input wire logic bus_idle_j_in,
    input wire logic [NUM_EP*EP_FLAG_W-1:0] ep_flags_in,
    output logic [udif_pkg::FRAME_NUMBER_W-1:0] frame_number_out,
    output logic [udif_pkg::MICROFRAME_NUMBER_W-1:0] microframe_number_out,
    output logic irq_out
);
    import udif_pkg::*;

    logic [FLAG_W-1:0] bus_flags;
    logic [FLAG_W-1:0] irq_enable;
    logic [FLAG_W-1:0] event_set;
    logic [FLAG_W-1:0] sw_clear;
    logic [FLAG_W-1:0] next_flags;
    logic [FLAG_W-1:0] next_enable;
    logic [NUM_EP-1:0] endpoint_irq_summary;
    logic suspend_pulse;
    logic [DATA_W-1:0] next_rdata;

    // register address match, used by several decoders
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // suspend detection after three idle frame periods
    // idle J timer
    udif_idle_timer #(
        .LIMIT(SUSPEND_CYCLES)
    ) u_idle (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .bus_idle_j_in(bus_idle_j_in),
        .suspend_pulse_out(suspend_pulse)
    );

    // endpoint summary vector, no software write path
    // per-endpoint summary bits
    udif_ep_summary #(
        .NUM_EP(NUM_EP),
        .EP_FLAG_W(EP_FLAG_W)
    ) u_summary (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .ep_flags_in(ep_flags_in),
        .summary_out(endpoint_irq_summary)
    );

    // hardware events feeding the sticky flags
    always_comb
    begin
        event_set = '0;
        event_set[BIT_END_OF_BUS_RESET_FLAG] = bus_reset_end_in;
        event_set[BIT_SOF] = sof_token_in;
        event_set[BIT_SUSPEND] = suspend_pulse;
    end

    // software clear mask; zeros in write data do nothing
    always_comb
    begin
        sw_clear = '0;
        if (reg_wr_in)
        begin
            if (hit(reg_addr_in, OFF_BUS_FLAGS))
            begin
                sw_clear = reg_wdata_in[FLAG_W-1:0] & FLAG_MASK;
            end
        end
    end

    // set wins so a coincident event is never lost
    always_comb
    begin
        next_flags = ((bus_flags & ~sw_clear) | event_set) & FLAG_MASK;
    end

    // sticky bus-event flags
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            bus_flags <= FLAGS_RST;
        else
            bus_flags <= next_flags;
    end

    // enable next state; the irq term uses it so a cleared enable drops irq at once
    always_comb
    begin
        next_enable = irq_enable;
        if (reg_wr_in)
        begin
            if (hit(reg_addr_in, OFF_IRQ_EN_SET))
                next_enable = irq_enable | (reg_wdata_in[FLAG_W-1:0] & FLAG_MASK);
            else if (hit(reg_addr_in, OFF_IRQ_EN_CLR))
                next_enable = irq_enable & ~reg_wdata_in[FLAG_W-1:0];
        end
    end

    // interrupt enables via separate clear and set registers
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            irq_enable <= FLAGS_RST;
        else
            irq_enable <= next_enable;
    end

    // frame number capture and microframe count
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            frame_number_out <= '0;
            microframe_number_out <= '0;
        end
        else if (sof_token_in)
        begin
            frame_number_out <= sof_frame_in;
            if (high_speed_in)
                microframe_number_out <= '0;
        end
        else if (high_speed_in && microframe_tick_in)
            microframe_number_out <= microframe_number_out + 1'b1;
    end

    // read mux; unmapped addresses read zero, both enable set and clear addresses read the enables
    always_comb
    begin
        next_rdata = '0;
        if (hit(reg_addr_in, OFF_BUS_FLAGS))
            next_rdata[FLAG_W-1:0] = bus_flags;
        else if (hit(reg_addr_in, OFF_IRQ_EN_SET) || hit(reg_addr_in, OFF_IRQ_EN_CLR))
            next_rdata[FLAG_W-1:0] = irq_enable;
        else if (hit(reg_addr_in, OFF_EP_SUMMARY))
            next_rdata[NUM_EP-1:0] = endpoint_irq_summary;
        else if (hit(reg_addr_in, OFF_FRAME))
            next_rdata[FRAME_NUMBER_W+MICROFRAME_NUMBER_W-1:0] = {frame_number_out, microframe_number_out};
    end

    // read data valid only the cycle after the strobe
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            reg_rdata_out <= '0;
        else if (reg_rd_in)
            reg_rdata_out <= next_rdata;
        else
            reg_rdata_out <= '0;
    end

    // registered interrupt from the next-state flags, no extra lag
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            irq_out <= 1'b0;
        else
            // endpoint term taken straight from ep_flags_in, not the summary; drops with endpoint idle
            irq_out <= (|(next_flags & next_enable)) |
                       (|ep_flags_in);
    end
endmodule : udif_top
`default_nettype wire

/* testbench/testbench.sv */
/* bench for udif_top with the host model, short suspend count.
   10 MHz clock; one verdict at the end. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import udif_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic [31:0] reg_rdata_out;
    logic [127:0] ep_flags_in = 128'h0;
    logic [10:0] sof_frame_in, frame_number_out;
    logic [2:0] microframe_number_out;
    logic bus_reset_end_in, sof_token_in, high_speed_in;
    logic microframe_tick_in, bus_idle_j_in, irq_out;
    logic [1:0] cmd = 2'h0;
    logic idle = 1'b0;
    logic hs = 1'b0;
    int n_fail = 0;
    int check_count = 0;
    // 100 ns period
    initial forever #50 clk_in = ~clk_in;
    udif_top #(.SUSPEND_CYCLES(20)) dut_u (.clk_in, .sys_rst_in, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .bus_reset_end_in,
        .sof_token_in, .sof_frame_in, .high_speed_in, .microframe_tick_in,
        .bus_idle_j_in, .ep_flags_in, .frame_number_out, .microframe_number_out, .irq_out);
    udif_host_model host_u (.clk_in, .cmd_in(cmd), .idle_in(idle), .hs_in(hs),
        .rst_end_out(bus_reset_end_in), .sof_out(sof_token_in), .frame_out(sof_frame_in),
        .tick_out(microframe_tick_in), .idle_out(bus_idle_j_in), .hs_out(high_speed_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // settle, compare, then back onto an edge
    task automatic see(input logic [2:0] w, input logic [31:0] exp);
        #1;
        chk(w == 0 ? 32'(irq_out) : w == 1 ? 32'(frame_number_out)
            : 32'(microframe_number_out), exp);
        @(posedge clk_in);
    endtask : see
    // each access holds its strobe one cycle, then a gap
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        @(posedge clk_in);
    endtask : wr
    // read data stand one cycle only, then fall back to zero
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(reg_rdata_out, exp);
        @(posedge clk_in);
        #1;
        chk(reg_rdata_out, 32'h0);
        @(posedge clk_in);
    endtask : rd
    task automatic host(input logic [1:0] c);
        cmd <= c;
        @(posedge clk_in);
        cmd <= 2'h0;
    endtask : host
    task automatic t_end_of_bus_reset_flag;
        rd(8'h40, 32'h0);
        wr(OFF_IRQ_EN_SET, 32'hd);
        host(2'h1);
        @(posedge clk_in);
        rd(OFF_BUS_FLAGS, 32'h8);
        see(3'h0, 32'h1);
        wr(OFF_BUS_FLAGS, 32'h0);
        rd(OFF_BUS_FLAGS, 32'h8);
        wr(OFF_IRQ_EN_CLR, 32'h8);
        see(3'h0, 32'h0);
        wr(OFF_IRQ_EN_SET, 32'h8);
        wr(OFF_BUS_FLAGS, 32'hc);
        rd(OFF_BUS_FLAGS, 32'h0);
        see(3'h0, 32'h0);
        $display("end of reset test done");
    endtask : t_end_of_bus_reset_flag
    task automatic t_sof;
        hs <= 1'b1;
        host(2'h3);
        @(posedge clk_in);
        host(2'h3);
        @(posedge clk_in);
        see(3'h2, 32'h2);
        host(2'h2);
        @(posedge clk_in);
        rd(OFF_BUS_FLAGS, 32'h4);
        see(3'h0, 32'h1);
        see(3'h1, 32'h7ff);
        see(3'h2, 32'h0);
        rd(OFF_FRAME, 32'h3ff8);
        host(2'h2);
        wr(OFF_BUS_FLAGS, 32'h4);
        rd(OFF_BUS_FLAGS, 32'h4);
        rd(OFF_FRAME, 32'h0);
        wr(OFF_BUS_FLAGS, 32'h4);
        rd(OFF_BUS_FLAGS, 32'h0);
        $display("start of frame test done");
    endtask : t_sof
    task automatic t_suspend;
        idle <= 1'b1;
        repeat (16) @(posedge clk_in);
        rd(OFF_BUS_FLAGS, 32'h0);
        repeat (8) @(posedge clk_in);
        rd(OFF_BUS_FLAGS, 32'h1);
        see(3'h0, 32'h1);
        wr(OFF_BUS_FLAGS, 32'h1);
        rd(OFF_BUS_FLAGS, 32'h0);
        idle <= 1'b0;
        $display("suspend test done");
    endtask : t_suspend
    task automatic t_ep;
        ep_flags_in <= {8'h80, 112'h0, 8'h01};
        @(posedge clk_in);
        rd(OFF_EP_SUMMARY, 32'h8001);
        see(3'h0, 32'h1);
        wr(OFF_EP_SUMMARY, 32'h0);
        rd(OFF_EP_SUMMARY, 32'h8001);
        ep_flags_in <= 128'h0;
        @(posedge clk_in);
        rd(OFF_EP_SUMMARY, 32'h0);
        see(3'h0, 32'h0);
        $display("endpoint summary test done");
    endtask : t_ep
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    // main sequence after 12 cycles of reset
    initial
    begin
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        t_end_of_bus_reset_flag();
        t_sof();
        t_suspend();
        t_ep();
        conclude();
    end
    // tests need about 120 cycles; cut a hang at 3000
    initial
    begin
        #300000;
        n_fail++;
        conclude();
    end
endmodule : testbench
`default_nettype wire

/* testbench/udif_chk_sva.sv */
/* checker watching udif_top ports, bound below.
   one clock, sync active-high reset. */
`timescale 1ns/10ps
`default_nettype none
module udif_chk
    import udif_pkg::*;
#(
    parameter int NUM_EP = 16,
    parameter int EP_FLAG_W = 8
)(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [DATA_W-1:0] reg_rdata_out,
    input wire logic bus_reset_end_in,
    input wire logic sof_token_in,
    input wire logic [FRAME_NUMBER_W-1:0] sof_frame_in,
    input wire logic high_speed_in,
    input wire logic [NUM_EP*EP_FLAG_W-1:0] ep_flags_in,
    input wire logic [FRAME_NUMBER_W-1:0] frame_number_out,
    input wire logic [MICROFRAME_NUMBER_W-1:0] microframe_number_out,
    input wire logic irq_out
);
    // flag register strobes
    wire logic rf = reg_rd_in && reg_addr_in == OFF_BUS_FLAGS;
    wire logic wf = reg_wr_in && reg_addr_in == OFF_BUS_FLAGS;
    wire logic ev = bus_reset_end_in || sof_token_in;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    a_frame_store: assert property (
        sof_token_in |=> frame_number_out == $past(sof_frame_in)) else $error("frame lost");
    a_mframe_clear: assert property (
        sof_token_in && high_speed_in |=> microframe_number_out == 3'h0) else $error("mframe");
    a_end_of_bus_reset_flag_sets: assert property (
        bus_reset_end_in ##1 rf |=> reg_rdata_out[BIT_END_OF_BUS_RESET_FLAG]) else $error("end_of_bus_reset_flag flag");
    a_sof_sets: assert property (
        sof_token_in ##1 rf |=> reg_rdata_out[BIT_SOF]) else $error("sof flag");
    a_ones_clear: assert property (
        wf && reg_wdata_in[3:2] == 2'h3 && !ev ##1 !wf && !ev ##1 rf && !ev
        |=> reg_rdata_out[3:2] == 2'h0)
        else $error("flags not cleared");
    a_set_wins: assert property (
        wf && reg_wdata_in[BIT_SOF] && sof_token_in ##1 !wf ##1 rf |=> reg_rdata_out[BIT_SOF])
        else $error("clear beat set");
    a_summary_idle: assert property (
        (ep_flags_in == '0)[*2] ##0 reg_rd_in && reg_addr_in == OFF_EP_SUMMARY
        |=> reg_rdata_out == 32'h0) else $error("summary stuck");
    a_ep_irq: assert property (
        |ep_flags_in |=> irq_out) else $error("endpoint irq missing");
endmodule : udif_chk
bind udif_top udif_chk #(.NUM_EP(NUM_EP), .EP_FLAG_W(EP_FLAG_W)) chk_u (.clk_in,
    .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .bus_reset_end_in, .sof_token_in, .sof_frame_in, .high_speed_in, .ep_flags_in,
    .frame_number_out, .microframe_number_out, .irq_out);
`default_nettype wire

/* testbench/udif_host_model.sv */
/* host-side model: bench commands become one-cycle bus events.
   commands change right after a rising edge. */
`timescale 1ns/10ps
`default_nettype none
module udif_host_model (
    input wire logic clk_in,
    input wire logic [1:0] cmd_in,
    input wire logic idle_in,
    input wire logic hs_in,
    output logic rst_end_out,
    output logic sof_out,
    output logic [10:0] frame_out,
    output logic tick_out,
    output logic idle_out,
    output logic hs_out
);
    // frame count starts near the top so the wrap is seen
    initial
    begin
        {rst_end_out, sof_out, tick_out, idle_out, hs_out} = 5'h0;
        frame_out = 11'h7fe;
    end
    // events last one cycle; frame advances per start of frame
    always @(posedge clk_in)
    begin
        rst_end_out <= cmd_in == 2'h1;
        sof_out <= cmd_in == 2'h2;
        tick_out <= cmd_in == 2'h3;
        idle_out <= idle_in;
        hs_out <= hs_in;
        frame_out <= frame_out + 11'(cmd_in == 2'h2);
    end
endmodule : udif_host_model
`default_nettype wire
